// >>> hdl/emc_pkg.sv
// constants, types and shared helpers for the extend mode control block
// assumes a single 200 MHz clock and a sequencer that issues phase strobes
// What this block does
// - decode enable-extended op 000013 and enter extend mode
// - disable op 000011 leaves extend mode only after a jump executes
// - master clear forces extend mode off
// - jump-and-store in extend mode stores a 15-bit program counter
// - jump-and-store keeps bit 1 of the target word unchanged
// - read-keys op copies prior mode flag into accumulator bit 3
// - write-keys op enables on accumulator bit 3 one, disables on zero
// - write-keys disable is deferred until a following jump executes
// - write-keys enable sets the extend flip-flop at next phase one
// - fetch phase four, bits 13 and 15 set: arm set; prior mode left as it is
// - fetch phase four, bit 13 set, bit 15 clear: arm deferred clear
// - both mode ops complete in one fetch cycle of 0.96 us
// - forced call sets extend mode and saves previous mode
// - prior mode cleared by interrupt outside extend mode or master clear
// - saved sector bit refreshed each fetch; drives address bit 15 when off
// - in extend mode indirect index bit becomes address bit 15
package emc_pkg;

  // ***************************************************************
  // opcodes and word layout (bit 1 is the word msb)
  // ***************************************************************
  localparam logic [15:0] EMC_OP_ENABLE  = 16'h000B;  // octal 000013
  localparam logic [15:0] EMC_OP_DISABLE = 16'h0009;  // octal 000011
  localparam int          EMC_BIT1_POS   = 15;        // word bit 1
  localparam int          EMC_BIT2_POS   = 14;        // word bit 2
  localparam int          EMC_BIT3_POS   = 13;        // word bit 3
  localparam int          EMC_PC_NARROW  = 14;
  localparam int          EMC_PC_WIDE    = 15;

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int EMC_CLK_PERIOD_PS = 5000;
  localparam int EMC_FETCH_TIME_PS = 960000;          // 0.96 us
  localparam int EMC_FETCH_CYCLES  =
    (EMC_FETCH_TIME_PS + EMC_CLK_PERIOD_PS - 1) / EMC_CLK_PERIOD_PS;
  localparam int EMC_TMR_W         = 8;

  // ***************************************************************
  // register map
  // ***************************************************************
  localparam logic [7:0]  EMC_ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  EMC_ADDR_STATUS = 8'h04;
  localparam int          EMC_CTRL_DECEN  = 0;        // decode enable
  localparam int          EMC_CTRL_SWSET  = 1;        // write one: enable
  localparam int          EMC_CTRL_SWCLR  = 2;        // write one: disable
  localparam logic        EMC_DECEN_RST   = 1'b1;
  localparam int          EMC_ST_EXT      = 0;
  localparam int          EMC_ST_PRIOR    = 1;
  localparam int          EMC_ST_DRAIN    = 2;
  localparam int          EMC_ST_SETPEND  = 3;
  localparam int          EMC_ST_SECTOR   = 4;
  localparam int          EMC_ST_BUSY     = 5;

  typedef enum logic [1:0] {
    EMC_MODE_NORMAL = 2'b00,
    EMC_MODE_EXTEND = 2'b01,
    EMC_MODE_DRAIN  = 2'b10
  } emc_mode_t;

  // true when the word is one of the two mode ops
  function automatic logic emc_is_mode_op(input logic [15:0] w);
    emc_is_mode_op = (w == EMC_OP_ENABLE) || (w == EMC_OP_DISABLE);
  endfunction : emc_is_mode_op

endpackage : emc_pkg

// >>> hdl/emc_sync2.sv
// two flip-flop synchroniser for a level from outside the clock domain
// assumes the level is slow compared with the clock
`timescale 1ns/10ps
module emc_sync2 (
  input  wire logic mclk,      // system clock
  input  wire logic rst_b,     // sync reset, active low
  input  wire logic asyncIn,   // level from a pin
  output logic      syncOut    // level in the mclk domain
);

  logic stage1_reg;

  // first stage read only by the second
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      stage1_reg <= 1'b0;
      syncOut    <= 1'b0;
    end else begin
      stage1_reg <= asyncIn;
      syncOut    <= stage1_reg;
    end
  end

endmodule : emc_sync2

// >>> hdl/emc_fetch_timer.sv
// counts out the fixed execution time of a single-cycle mode op
// assumes a start pulse only while idle; later starts are ignored
`timescale 1ns/10ps
module emc_fetch_timer
  import emc_pkg::*;
(
  input  wire logic mclk,      // system clock
  input  wire logic rst_b,     // sync reset, active low
  input  wire logic start,     // one-cycle start pulse
  output logic      busy,      // timer running
  output logic      done       // one-cycle pulse at the end
);

  localparam logic [EMC_TMR_W-1:0] LAST = EMC_TMR_W'(EMC_FETCH_CYCLES - 1);

  logic [EMC_TMR_W-1:0] count_reg;

  // count from start to the last cycle of the fetch, then pulse done
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      count_reg <= '0;
      busy      <= 1'b0;
      done      <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!busy && start) begin
        busy      <= 1'b1;
        count_reg <= '0;
      end else if (busy && count_reg == LAST) begin
        busy <= 1'b0;
        done <= 1'b1;
      end else if (busy) begin
        count_reg <= count_reg + 1'b1;
      end
    end
  end

endmodule : emc_fetch_timer

// >>> hdl/extend_mode_control.sv
// extend mode control: mode op decode, mode flip-flops and keys/store hooks
// assumes sequencer strobes run on mclk; master clear button is asynchronous
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/10ps
module extend_mode_control
  import emc_pkg::*;
(
  input  wire logic        mclk,              // 200 MHz clock
  input  wire logic        rst_b,             // sync reset, active low
  // apb slave
  input  wire logic        psel,              // apb select
  input  wire logic        penable,           // apb access phase
  input  wire logic        pwrite,            // apb write
  input  wire logic [7:0]  paddr,             // apb byte address
  input  wire logic [31:0] pwdata,            // apb write data
  output logic [31:0]      prdata,            // apb read data
  output logic             pready,            // apb ready
  output logic             pslverr,           // apb error
  // sequencer side
  input  wire logic        masterClearButton, // pushbutton, asynchronous
  input  wire logic        fetchCycle,        // fetch cycle level
  input  wire logic        phaseOne,          // phase one strobe
  input  wire logic        phaseFour,         // phase four strobe
  input  wire logic [15:0] instrWord,         // instruction register
  input  wire logic        jumpOpExec,        // jump op executed, pulse
  input  wire logic        forcedCallStrobe,  // interrupt forced call
  input  wire logic        jumpAndStore,      // store phase of call, pulse
  input  wire logic [14:0] progCounter,       // program counter
  input  wire logic [15:0] targetWordIn,      // old word at store target
  input  wire logic        readKeysOp,        // read-keys op, pulse
  input  wire logic [15:0] keysWordIn,        // keys word from cpu
  input  wire logic        writeKeysOp,       // write-keys op, pulse
  input  wire logic [15:0] accWord,           // accumulator
  input  wire logic        addrHighIn,        // computed address bit 15
  input  wire logic        indirectCycle,     // indirect cycle level
  input  wire logic        indexBit,          // index bit of word
  output logic             extendModeFf,      // extend mode flip-flop
  output logic             priorModeFf,       // prior mode flip-flop
  output logic             setExtendPulse,    // set pulse toward phase one
  output logic [15:0]      storeWord,         // word written by call
  output logic [15:0]      keysWordOut,       // keys word to accumulator
  output logic             operandAddrHigh,   // operand address bit 15
  output logic             indexEnable,       // indexing permitted
  output logic             modeOpBusy,        // mode op timing running
  output logic             modeOpDone         // mode op complete, pulse
);

  // ***************************************************************
  // declarations
  // ***************************************************************
  emc_mode_t   mode_reg;
  emc_mode_t   mode_next;
  logic        prior_reg;
  logic        setPend_reg;
  logic        sector_reg;
  logic        decEn_reg;
  logic        masterClear;
  logic        clearAll;
  logic        apbWrite;
  logic        apbRead;
  logic        addrHit;
  logic        swSet;
  logic        swClr;
  logic        decodeSlot;
  logic        enableOp;
  logic        disableOp;
  logic        keysEnable;
  logic        keysDisable;
  logic        setReq;
  logic        clrReq;
  logic        extendNow;
  logic [15:0] storeNext;
  logic [15:0] keysNext;
  logic [31:0] statusWord;

  // ***************************************************************
  // master clear input
  // ***************************************************************
  // the button comes from a pin, so it is synchronised first
  emc_sync2 u_mclr_sync (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .asyncIn (masterClearButton),
    .syncOut (masterClear)
  );

  assign clearAll = masterClear;

  // ***************************************************************
  // apb slave
  // ***************************************************************
  // zero wait state: every access completes in its first access cycle
  assign pready   = 1'b1;
  assign addrHit  = (paddr == EMC_ADDR_CTRL) || (paddr == EMC_ADDR_STATUS);
  assign apbWrite = psel && penable && pwrite;
  assign apbRead  = psel && penable && !pwrite;
  assign pslverr  = psel && penable && !addrHit;

  // write-one request bits are pulses, they are not stored
  assign swSet = apbWrite && (paddr == EMC_ADDR_CTRL) && pwdata[EMC_CTRL_SWSET];
  assign swClr = apbWrite && (paddr == EMC_ADDR_CTRL) && pwdata[EMC_CTRL_SWCLR];

  // decode enable: lets software mask the mode ops during bring-up
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      decEn_reg <= EMC_DECEN_RST;
    end else if (apbWrite && paddr == EMC_ADDR_CTRL) begin
      decEn_reg <= pwdata[EMC_CTRL_DECEN];
    end
  end

  // status gathered from the block's own state
  always_comb begin
    statusWord                 = '0;
    statusWord[EMC_ST_EXT]     = extendNow;
    statusWord[EMC_ST_PRIOR]   = prior_reg;
    statusWord[EMC_ST_DRAIN]   = (mode_reg == EMC_MODE_DRAIN);
    statusWord[EMC_ST_SETPEND] = setPend_reg;
    statusWord[EMC_ST_SECTOR]  = sector_reg;
    statusWord[EMC_ST_BUSY]    = modeOpBusy;
  end

  // read data registered in the setup cycle; unmapped reads return zero
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == EMC_ADDR_CTRL) begin
        prdata <= {31'h00000000, decEn_reg};
      end else if (paddr == EMC_ADDR_STATUS) begin
        prdata <= statusWord;
      end else begin
        prdata <= '0;
      end
    end
  end

  // ***************************************************************
  // mode op decode
  // ***************************************************************
  // ops are sampled once, in the fetch cycle at phase four
  assign decodeSlot = fetchCycle && phaseFour && decEn_reg;
  assign enableOp   = decodeSlot && (instrWord == EMC_OP_ENABLE);
  assign disableOp  = decodeSlot && (instrWord == EMC_OP_DISABLE);

  // write-keys picks the direction from accumulator bit 3
  assign keysEnable  = writeKeysOp && accWord[EMC_BIT3_POS];
  assign keysDisable = writeKeysOp && !accWord[EMC_BIT3_POS];

  // every source of a set or a deferred clear, software included
  assign setReq = enableOp || keysEnable || swSet;
  assign clrReq = disableOp || keysDisable || swClr;

  // the set pulse is the armed request, seen by the next phase one
  assign setExtendPulse = setPend_reg;

  // ***************************************************************
  // set arm: carries a set request to the next phase one
  // ***************************************************************
  // a new request in the consuming cycle re-arms, so it is never lost
  always_ff @(posedge mclk) begin
    if (!rst_b || clearAll) begin
      setPend_reg <= 1'b0;
    end else if (setReq) begin
      setPend_reg <= 1'b1;
    end else if (clrReq || phaseOne || forcedCallStrobe) begin
      setPend_reg <= 1'b0;
    end
  end

  // ***************************************************************
  // mode state machine
  // ***************************************************************
  // drain holds the mode set until a jump executes
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      EMC_MODE_NORMAL: begin
        if (forcedCallStrobe || (setPend_reg && phaseOne)) begin
          mode_next = EMC_MODE_EXTEND;
        end
      end
      EMC_MODE_EXTEND: begin
        if (forcedCallStrobe) begin
          mode_next = EMC_MODE_EXTEND;
        end else if (clrReq) begin
          mode_next = EMC_MODE_DRAIN;
        end
      end
      EMC_MODE_DRAIN: begin
        // a set arriving with the jump wins over the deferred clear
        if (forcedCallStrobe || (setPend_reg && phaseOne)) begin
          mode_next = EMC_MODE_EXTEND;
        end else if (setReq) begin
          mode_next = EMC_MODE_EXTEND;
        end else if (jumpOpExec) begin
          mode_next = EMC_MODE_NORMAL;
        end
      end
      default: begin
        mode_next = EMC_MODE_NORMAL;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b || clearAll) begin
      mode_reg <= EMC_MODE_NORMAL;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // extend mode is set in both extend and drain states
  assign extendNow    = (mode_reg != EMC_MODE_NORMAL);
  assign extendModeFf = extendNow;

  // ***************************************************************
  // prior mode flip-flop
  // ***************************************************************
  // the call strobe samples the mode held just before it is forced on
  always_ff @(posedge mclk) begin
    if (!rst_b || clearAll) begin
      prior_reg <= 1'b0;
    end else if (forcedCallStrobe) begin
      prior_reg <= extendNow;
    end
  end

  assign priorModeFf = prior_reg;

  // ***************************************************************
  // saved sector bit and address bit 15
  // ***************************************************************
  // refreshed at every fetch so a normal-mode program stays in its half
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sector_reg <= 1'b0;
    end else if (fetchCycle && phaseOne) begin
      sector_reg <= progCounter[EMC_PC_WIDE-1];
    end
  end

  // indirect words in extend mode give address bit 15 from the index bit
  always_comb begin
    if (!extendNow) begin
      operandAddrHigh = sector_reg;
      indexEnable     = indexBit;
    end else if (indirectCycle) begin
      operandAddrHigh = indexBit;
      indexEnable     = 1'b0;
    end else begin
      operandAddrHigh = addrHighIn;
      indexEnable     = indexBit;
    end
  end

  // ***************************************************************
  // jump-and-store word
  // ***************************************************************
  // bit 1 always survives; bit 2 is only overwritten in extend mode
  always_comb begin
    storeNext                      = targetWordIn;
    storeNext[EMC_PC_NARROW-1:0]   = progCounter[EMC_PC_NARROW-1:0];
    if (extendNow) begin
      storeNext[EMC_BIT2_POS]      = progCounter[EMC_PC_WIDE-1];
    end
    storeNext[EMC_BIT1_POS]        = targetWordIn[EMC_BIT1_POS];
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      storeWord <= '0;
    end else if (jumpAndStore) begin
      storeWord <= storeNext;
    end
  end

  // ***************************************************************
  // read-keys word
  // ***************************************************************
  always_comb begin
    keysNext               = keysWordIn;
    keysNext[EMC_BIT3_POS] = prior_reg;
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      keysWordOut <= '0;
    end else if (readKeysOp) begin
      keysWordOut <= keysNext;
    end
  end

  // ***************************************************************
  // mode op execution time
  // ***************************************************************
  // the sequencer may hold its next fetch on busy
  emc_fetch_timer u_timer (
    .mclk  (mclk),
    .rst_b (rst_b),
    .start (decodeSlot && emc_is_mode_op(instrWord)),
    .busy  (modeOpBusy),
    .done  (modeOpDone)
  );

endmodule : extend_mode_control

// >>> tb/emc_asserts.sv
// checker for the extend mode control block, bound to its top module
// assumes decode enable is left at its reset value by software
`timescale 1ns/10ps
module emc_asserts
  import emc_pkg::*;
(
  input wire logic        mclk,              // clock
  input wire logic        rst_b,             // reset, active low
  input wire logic        masterClearButton, // master clear
  input wire logic        fetchCycle,        // fetch level
  input wire logic        phaseOne,          // phase one
  input wire logic        phaseFour,         // phase four
  input wire logic [15:0] instrWord,         // instruction
  input wire logic        jumpOpExec,        // jump executed
  input wire logic        forcedCallStrobe,  // forced call
  input wire logic        jumpAndStore,      // store strobe
  input wire logic [14:0] progCounter,       // program counter
  input wire logic [15:0] targetWordIn,      // old target word
  input wire logic        readKeysOp,        // read keys
  input wire logic        indirectCycle,     // indirect level
  input wire logic        indexBit,          // index bit
  input wire logic        extendModeFf,      // extend mode
  input wire logic        priorModeFf,       // prior mode
  input wire logic        setExtendPulse,    // set arm
  input wire logic [15:0] storeWord,         // stored word
  input wire logic [15:0] keysWordOut,       // keys word
  input wire logic        operandAddrHigh,   // address bit 15
  input wire logic        indexEnable,       // indexing allowed
  input wire logic        modeOpBusy,        // op timing
  input wire logic        modeOpDone         // op done
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // ***************************************************************
  // mode op decode and timing
  // ***************************************************************
  sequence s_decode;
    fetchCycle && phaseFour && !modeOpBusy &&
      (instrWord == EMC_OP_ENABLE || instrWord == EMC_OP_DISABLE);
  endsequence
  sequence s_timed;
    ##1 modeOpBusy ##[188:194] modeOpDone;
  endsequence
  a_fetch_time: assert property (s_decode |-> s_timed)
    else $error("mode op timing wrong");
  a_enable_arm: assert property (fetchCycle && phaseFour
    && instrWord == EMC_OP_ENABLE |=> setExtendPulse)
    else $error("enable op did not arm set");
  // the synchronised clear lags the button by two edges
  a_set_phase: assert property (setExtendPulse && phaseOne
    && !$past(masterClearButton, 2) |=> extendModeFf)
    else $error("set arm not taken at phase one");
  // a fall of the mode is only legal after a jump or a master clear
  a_disable_defer: assert property ($fell(extendModeFf) |-> $past(jumpOpExec) ||
    $past(masterClearButton, 2) || $past(masterClearButton, 3) || $past(masterClearButton, 4))
    else $error("extend mode left without jump");
  a_mclear_off: assert property (masterClearButton [*4]
    |=> !extendModeFf && !priorModeFf)
    else $error("master clear left mode set");
  a_forced_call: assert property (forcedCallStrobe
    |=> extendModeFf && priorModeFf == $past(extendModeFf))
    else $error("forced call mode save wrong");
  a_store_word: assert property (jumpAndStore
    |=> storeWord[15] == $past(targetWordIn[15]) && storeWord[13:0] == $past(progCounter[13:0])
    && storeWord[14] == ($past(extendModeFf) ? $past(progCounter[14]) : $past(targetWordIn[14])))
    else $error("stored word wrong");
  a_keys_prior: assert property (readKeysOp
    |=> keysWordOut[EMC_BIT3_POS] == $past(priorModeFf))
    else $error("keys bit 3 wrong");
  a_index_high: assert property (extendModeFf && indirectCycle
    |-> operandAddrHigh == indexBit && !indexEnable)
    else $error("indirect high bit wrong");
endmodule : emc_asserts

bind extend_mode_control emc_asserts u_emc_asserts (.*);

// >>> tb/emc_seq_model.sv
// sequencer model: fetch level and phase strobes in an eight clock frame
// assumes the bench drives instruction words and op pulses itself
`timescale 1ns/10ps
module emc_seq_model (
  input  wire logic mclk,       // clock
  input  wire logic rst_b,      // reset, active low
  output logic      fetchCycle, // fetch level
  output logic      phaseOne,   // phase one strobe
  output logic      phaseFour   // phase four strobe
);
  logic [2:0] phaseCnt_reg;
  // strobes never overlap, so a set arm and a decode cannot collide
  always_ff @(posedge mclk) begin
    phaseCnt_reg <= rst_b ? phaseCnt_reg + 3'h1 : 3'h0;
    fetchCycle   <= rst_b;
    phaseOne     <= rst_b && (phaseCnt_reg == 3'h0);
    phaseFour    <= rst_b && (phaseCnt_reg == 3'h3);
  end
endmodule : emc_seq_model

// >>> tb/extend_mode_control_tb.sv
// bench for the extend mode control block with a sequencer model
// assumes zero wait apb and decode enable at reset value
`timescale 1ns/10ps
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin error_cnt++; \
  $display("wrong value %s exp %h got %h", nm, e, s); end end
module extend_mode_control_tb
  import emc_pkg::*;
;
  localparam logic [15:0] NEU = 16'h1234;  // neither mode op
  logic mclk, rst_b, psel, penable, pwrite, masterClearButton, fetchCycle, phaseOne;
  logic phaseFour, jumpOpExec, forcedCallStrobe, jumpAndStore, readKeysOp, writeKeysOp;
  logic addrHighIn, indirectCycle, indexBit, pready, pslverr, extendModeFf, priorModeFf;
  logic setExtendPulse, operandAddrHigh, indexEnable, modeOpBusy, modeOpDone, apbErr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, apbRdata;
  logic [15:0] instrWord, targetWordIn, keysWordIn, accWord, storeWord, keysWordOut;
  logic [14:0] progCounter;
  int          error_cnt, checks;
  extend_mode_control u_extend_mode_control (.mclk(mclk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .masterClearButton(masterClearButton),
    .fetchCycle(fetchCycle), .phaseOne(phaseOne), .phaseFour(phaseFour),
    .instrWord(instrWord), .jumpOpExec(jumpOpExec), .forcedCallStrobe(forcedCallStrobe),
    .jumpAndStore(jumpAndStore), .progCounter(progCounter), .targetWordIn(targetWordIn),
    .readKeysOp(readKeysOp), .keysWordIn(keysWordIn), .writeKeysOp(writeKeysOp),
    .accWord(accWord), .addrHighIn(addrHighIn), .indirectCycle(indirectCycle),
    .indexBit(indexBit), .extendModeFf(extendModeFf), .priorModeFf(priorModeFf),
    .setExtendPulse(setExtendPulse), .storeWord(storeWord), .keysWordOut(keysWordOut),
    .operandAddrHigh(operandAddrHigh), .indexEnable(indexEnable),
    .modeOpBusy(modeOpBusy), .modeOpDone(modeOpDone));
  emc_seq_model u_emc_seq_model (.mclk(mclk), .rst_b(rst_b), .fetchCycle(fetchCycle),
    .phaseOne(phaseOne), .phaseFour(phaseFour));
  // ***************************************************************
  // shared tasks
  // ***************************************************************
  task automatic give_verdict();
    if (error_cnt == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask : cyc
  // apb master; the answer is awaited, never assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge mclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin error_cnt++; give_verdict(); end
    apbRdata = prdata;
    apbErr = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  // one cycle op pulse: 0 jump, 1 call, 2 store, 3 read keys, 4 write keys
  task automatic pulse(input int k);
    @(posedge mclk);
    case (k)
      0: jumpOpExec <= 1'b1;
      1: forcedCallStrobe <= 1'b1;
      2: jumpAndStore <= 1'b1;
      3: readKeysOp <= 1'b1;
      default: writeKeysOp <= 1'b1;
    endcase
    @(posedge mclk);
    {jumpOpExec, forcedCallStrobe, jumpAndStore, readKeysOp, writeKeysOp} <= 5'h00;
    @(negedge mclk);
  endtask : pulse
  // word stays up for exactly one phase four so it decodes once
  task automatic do_op(input logic [15:0] w);
    int n;
    @(posedge mclk);
    instrWord <= w;
    n = 0;
    do begin @(negedge mclk); n++; end while (phaseFour !== 1'b1 && n < 20);
    if (n >= 20) begin error_cnt++; give_verdict(); end
    @(posedge mclk);
    instrWord <= NEU;
  endtask : do_op
  // ***************************************************************
  // scenarios
  // ***************************************************************
  task automatic t_enable();
    int n;
    do_op(EMC_OP_ENABLE);
    @(negedge mclk);
    `CHK("arm", 1'b1, setExtendPulse)
    `CHK("busy", 1'b1, modeOpBusy)
    n = 0;
    do begin @(negedge mclk); n++; end while (modeOpDone !== 1'b1 && n < 300);
    `CHK("ext", 1'b1, extendModeFf)
    `CHK("time", 1'b1, n >= 188 && n <= 194)
  endtask : t_enable
  task automatic t_store(input logic x);
    @(posedge mclk);
    progCounter <= 15'h2AAA;
    targetWordIn <= 16'hFFFF;
    pulse(2);
    `CHK("store", x ? 16'hAAAA : 16'hEAAA, storeWord)
  endtask : t_store
  task automatic t_index();
    @(posedge mclk);
    {indirectCycle, indexBit, addrHighIn} <= 3'b110;
    @(negedge mclk);
    `CHK("high", 1'b1, operandAddrHigh)
    `CHK("idx", 1'b0, indexEnable)
    @(posedge mclk);
    {indirectCycle, indexBit} <= 2'b00;
  endtask : t_index
  task automatic t_keys();
    pulse(1);
    `CHK("prior", 1'b1, priorModeFf)
    pulse(3);
    `CHK("keys", 16'h2000, keysWordOut)
    @(posedge mclk) accWord <= 16'h0000;
    pulse(4);
    cyc(24);
    `CHK("ext", 1'b1, extendModeFf)
    pulse(0);
    `CHK("ext", 1'b0, extendModeFf)
    pulse(1);
    `CHK("prior", 1'b0, priorModeFf)
    `CHK("ext", 1'b1, extendModeFf)
    do_op(EMC_OP_DISABLE);
    cyc(24);
    `CHK("ext", 1'b1, extendModeFf)
    pulse(0);
    `CHK("ext", 1'b0, extendModeFf)
    @(posedge mclk) accWord <= 16'h2000;
    pulse(4);
    cyc(10);
    `CHK("ext", 1'b1, extendModeFf)
  endtask : t_keys
  task automatic t_mclear();
    pulse(1);
    @(posedge mclk);
    masterClearButton <= 1'b1;
    cyc(4);
    @(posedge mclk);
    masterClearButton <= 1'b0;
    cyc(3);
    `CHK("ext", 1'b0, extendModeFf)
    `CHK("prior", 1'b0, priorModeFf)
  endtask : t_mclear
  task automatic t_sector();
    @(posedge mclk);
    progCounter <= 15'h4000;
    cyc(10);
    `CHK("sector", 1'b1, operandAddrHigh)
  endtask : t_sector
  task automatic t_apb();
    apb(1'b0, 8'h40, 32'h0);
    `CHK("err", 1'b1, apbErr)
    `CHK("rd", 32'h0, apbRdata)
    apb(1'b1, EMC_ADDR_CTRL, 32'h3);
    cyc(10);
    apb(1'b1, EMC_ADDR_CTRL, 32'h5);
    apb(1'b0, EMC_ADDR_STATUS, 32'h0);
    `CHK("st", 3'h5, apbRdata[EMC_ST_DRAIN:EMC_ST_EXT])
  endtask : t_apb
  // ***************************************************************
  // clock, reset and main sequence
  // ***************************************************************
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    give_verdict();
  end
  initial begin
    {rst_b, psel, penable, pwrite, paddr, pwdata, masterClearButton} = '0;
    {jumpOpExec, forcedCallStrobe, jumpAndStore, readKeysOp, writeKeysOp} = '0;
    {addrHighIn, indirectCycle, indexBit, progCounter, targetWordIn} = '0;
    {keysWordIn, accWord, error_cnt, checks} = '0;
    instrWord = NEU;
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    cyc(1);
    `CHK("ext", 1'b0, extendModeFf)
    t_enable();
    t_store(1'b1);
    t_index();
    t_keys();
    t_mclear();
    t_store(1'b0);
    t_sector();
    t_apb();
    give_verdict();
  end
endmodule : extend_mode_control_tb
